// File: hdl/rtc_defines.svh
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// register byte offsets
`define OFS_SECOND 8'h00
`define OFS_MONTH  8'h04
`define OFS_YEAR   8'h08
`define OFS_GUARD  8'h0C
`define OFS_SRCSEL 8'h10
`define OFS_IEN    8'h14
`define OFS_IFLAG  8'h18
`define OFS_PRIO   8'h1C
`define OFS_IMASK  8'h20

// reset values
`define MONTH_RST  8'h01
`define YEAR_RST   8'h00
`define GUARD_RST  8'h00
`define SRCSEL_RST 8'h00
`define IEN_RST    8'h00
`define IFLAG_RST  8'h00
`define PRIO_RST   8'h00
`define IMASK_RST  8'h00

// field positions
`define BUSY_BIT   7
`define GUARD_BIT  7
`define SRCSEL_BIT 5
`define SEC_EN_BIT 2
`define PEND_BIT   1
`define PRIO_MSB   2
`define MONTH_MSB  4

// timing
`define CLK_HZ        25000000
`define TICK_PERIOD_S 1

`endif

// File: hdl/rtc_pkg.sv
package rtc_pkg;

  typedef logic [7:0] reg8_t;

  typedef enum logic {
    BUS_IDLE,
    BUS_READ
  } bus_state_t;

endpackage

// File: hdl/cal_if.sv
interface cal_if;

  logic              adv;
  logic              wr_month;
  logic              wr_year;
  rtc_pkg::reg8_t    wdata;
  rtc_pkg::reg8_t    month;
  rtc_pkg::reg8_t    year;

  modport ctrl
  (
    output adv,
    output wr_month,
    output wr_year,
    output wdata,
    input  month,
    input  year
  );

  modport cnt
  (
    input  adv,
    input  wr_month,
    input  wr_year,
    input  wdata,
    output month,
    output year
  );

endinterface

// File: hdl/month_year_counter.sv
`include "rtc_defines.svh"

module month_year_counter
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // calendar port
  cal_if.cnt        cal
);

  rtc_pkg::reg8_t month_q;
  rtc_pkg::reg8_t year_q;
  logic           wrap_month;

  // month 12 rolls to 01 and carries a year
  assign wrap_month = (month_q == 8'h12);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      month_q <= `MONTH_RST;
    end
    else if (cal.wr_month)
    begin
      // only b4..b0 exist; tens digit is a single bit
      month_q <= {3'h0, cal.wdata[`MONTH_MSB:0]};
    end
    else if (cal.adv)
    begin
      if (wrap_month)
      begin
        month_q <= 8'h01;
      end
      else if (month_q[3:0] == 4'h9)
      begin
        month_q <= 8'h10;
      end
      else
      begin
        month_q <= {3'h0, month_q[4], month_q[3:0] + 4'h1};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      year_q <= `YEAR_RST;
    end
    else if (cal.wr_year)
    begin
      year_q <= cal.wdata;
    end
    else if (cal.adv && wrap_month)
    begin
      if (year_q[3:0] != 4'h9)
      begin
        year_q <= {year_q[7:4], year_q[3:0] + 4'h1};
      end
      else if (year_q[7:4] != 4'h9)
      begin
        year_q <= {year_q[7:4] + 4'h1, 4'h0};
      end
      else
      begin
        // 99 wraps to 00
        year_q <= 8'h00;
      end
    end
  end

  assign cal.month = month_q;
  assign cal.year  = year_q;

endmodule

// File: hdl/rtc_calendar_irq.sv
// Implementation choices: the AHB-Lite interface to the registers and the register addresses.
`include "rtc_defines.svh"

module rtc_calendar_irq
#(
  parameter int unsigned TICKS_PER_SEC = `TICK_PERIOD_S * `CLK_HZ
)
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // carry from the date counter, one pulse per month end
  input  wire logic        month_carry,
  // interrupt
  output logic             irq,
  output logic      [2:0]  irq_level
);

  cal_if cal ();

  rtc_pkg::bus_state_t state_q;
  logic                hreadyout_q;
  logic [31:0]         hrdata_q;
  logic                wr_pend_q;
  logic [7:0]          addr_q;
  logic                accept;
  logic                wr_now;
  rtc_pkg::reg8_t      wbyte;

  rtc_pkg::reg8_t      guard_q;
  rtc_pkg::reg8_t      srcsel_q;
  rtc_pkg::reg8_t      ien_q;
  rtc_pkg::reg8_t      prio_q;
  rtc_pkg::reg8_t      imask_q;
  logic                pend_q;
  logic                busy_q;
  logic                irq_q;
  logic [2:0]          irq_level_q;

  logic [31:0]         div_q;
  logic                sec_tick;
  logic                time_wr_ok;
  logic                wr_month;
  logic                wr_year;
  logic                sec_event;
  rtc_pkg::reg8_t      rd_mux;

  // bus address phase and data phase
  assign accept = hsel && hready && htrans[1];
  assign wr_now = wr_pend_q;
  assign wbyte  = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end
    else if (accept)
    begin
      wr_pend_q <= hwrite;
      addr_q    <= haddr[7:0];
    end
    else
    begin
      wr_pend_q <= 1'b0;
    end
  end

  // reads take one wait state so that read data comes straight from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q     <= rtc_pkg::BUS_IDLE;
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        rtc_pkg::BUS_IDLE:
        begin
          if (accept && !hwrite)
          begin
            state_q     <= rtc_pkg::BUS_READ;
            hreadyout_q <= 1'b0;
          end
        end
        rtc_pkg::BUS_READ:
        begin
          state_q     <= rtc_pkg::BUS_IDLE;
          hreadyout_q <= 1'b1;
          hrdata_q    <= {24'h00_0000, rd_mux};
        end
        default:
        begin
          state_q     <= rtc_pkg::BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
      endcase
    end
  end

  always_comb
  begin
    case (addr_q)
      `OFS_SECOND: rd_mux = {busy_q, 7'h00};
      `OFS_MONTH:  rd_mux = cal.month;
      `OFS_YEAR:   rd_mux = cal.year;
      `OFS_GUARD:  rd_mux = guard_q;
      `OFS_SRCSEL: rd_mux = srcsel_q;
      `OFS_IEN:    rd_mux = ien_q;
      `OFS_IFLAG:  rd_mux = {6'h00, pend_q, 1'b0};
      `OFS_PRIO:   rd_mux = prio_q;
      `OFS_IMASK:  rd_mux = imask_q;
      default:     rd_mux = 8'h00;
    endcase
  end

  // one-second enable from the system clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q <= 32'h0000_0000;
    end
    else if (div_q == TICKS_PER_SEC - 1)
    begin
      div_q <= 32'h0000_0000;
    end
    else
    begin
      div_q <= div_q + 32'h0000_0001;
    end
  end

  assign sec_tick = (div_q == TICKS_PER_SEC - 1);

  // time data writes pass only while the guard bit is 1
  assign time_wr_ok = guard_q[`GUARD_BIT];
  assign wr_month   = wr_now && (addr_q == `OFS_MONTH) && time_wr_ok;
  assign wr_year    = wr_now && (addr_q == `OFS_YEAR) && time_wr_ok;

  assign cal.adv      = month_carry;
  assign cal.wr_month = wr_month;
  assign cal.wr_year  = wr_year;
  assign cal.wdata    = wbyte;

  month_year_counter u_cnt
  (
    .hclk    (hclk),
    .hresetn (hresetn),
    .cal     (cal.cnt)
  );

  // control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      guard_q <= `GUARD_RST;
    end
    else if (wr_now && addr_q == `OFS_GUARD)
    begin
      guard_q <= {wbyte[`GUARD_BIT], 7'h00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      srcsel_q <= `SRCSEL_RST;
    end
    else if (wr_now && addr_q == `OFS_SRCSEL)
    begin
      srcsel_q <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ien_q <= `IEN_RST;
    end
    else if (wr_now && addr_q == `OFS_IEN)
    begin
      ien_q <= wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prio_q <= `PRIO_RST;
    end
    else if (wr_now && addr_q == `OFS_PRIO)
    begin
      prio_q <= {5'h00, wbyte[`PRIO_MSB:0]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      imask_q <= `IMASK_RST;
    end
    else if (wr_now && addr_q == `OFS_IMASK)
    begin
      imask_q <= {6'h00, wbyte[`PEND_BIT], 1'b0};
    end
  end

  // per-second event, gated by its enable
  assign sec_event = sec_tick && ien_q[`SEC_EN_BIT];

  // a new second beats a clear written in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_q <= `IFLAG_RST == 8'h00 ? 1'b0 : 1'b1;
    end
    else if (sec_event)
    begin
      pend_q <= 1'b1;
    end
    else if (wr_now && addr_q == `OFS_IFLAG && !wbyte[`PEND_BIT])
    begin
      pend_q <= 1'b0;
    end
  end

  // busy covers any cycle in which a time register changes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= wr_month || wr_year || month_carry;
    end
  end

  // interrupt line and its priority level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      // select 1 hands the line to another source not built here
      irq_q <= pend_q && imask_q[`PEND_BIT] && !srcsel_q[`SRCSEL_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_level_q <= 3'h0;
    end
    else
    begin
      irq_level_q <= prio_q[`PRIO_MSB:0];
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp     = 1'b0;
  assign irq       = irq_q;
  assign irq_level = irq_level_q;

endmodule

// File: verification/rtc_calendar_irq_assertions.sv
`include "rtc_defines.svh"
module rtc_calendar_irq_checker
(
  // bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // interrupt
  input wire logic        irq,
  input wire logic [2:0]  irq_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_q;
  wire  take = hsel && hready && htrans[1];
  // open read data phase, so hrdata changes can be tied to it
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rd_q <= 1'b0;
    else if (take && !hwrite)
      rd_q <= 1'b1;
    else if (hreadyout)
      rd_q <= 1'b0;
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_ready_idle: assert property (!rd_q |-> hreadyout)
    else $error("wait state outside read");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read not one wait state");
  a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  a_data_hold: assert property ($changed(hrdata) |-> rd_q)
    else $error("read data changed outside read");
  a_level_copy: assert property (take && hwrite && haddr[7:0] == `OFS_PRIO
    |-> ##3 irq_level == $past(hwdata[2:0], 2))
    else $error("priority not reported");
  a_src_block: assert property (take && hwrite && haddr[7:0] == `OFS_SRCSEL
    ##1 hwdata[5] |-> ##2 !irq)
    else $error("irq with other source");
  a_reset_quiet: assert property ($rose(hresetn) |-> !irq && irq_level == 3'b000)
    else $error("outputs active after reset");
endmodule
bind rtc_calendar_irq rtc_calendar_irq_checker rtc_calendar_irq_checker_i
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .irq_level(irq_level)
);

// File: verification/rtc_calendar_irq_test.sv
`include "rtc_defines.svh"
module rtc_calendar_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        month_carry;
  logic        irq;
  logic [2:0]  irq_level;
  int          n_errors;
  int          n_compared;

  // short second keeps the interrupt tests brief
  rtc_calendar_irq #(.TICKS_PER_SEC(20)) rtc_calendar_irq_i
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .month_carry(month_carry),
    .irq(irq), .irq_level(irq_level)
  );

  always #20 hclk = ~hclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    check(hrdata, {24'h00_0000, e});
  endtask

  task automatic carry;
    month_carry <= 1'b1;
    @(posedge hclk);
    month_carry <= 1'b0;
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    month_carry = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`OFS_MONTH, 8'h01);
    rd(`OFS_YEAR, 8'h00);
    rd(`OFS_GUARD, 8'h00);
    wr(`OFS_MONTH, 8'h09);
    rd(`OFS_MONTH, 8'h01);
    wr(`OFS_GUARD, 8'h80);
    rd(`OFS_GUARD, 8'h80);
    wr(`OFS_MONTH, 8'h09);
    carry();
    rd(`OFS_MONTH, 8'h10);
    wr(`OFS_MONTH, 8'h12);
    wr(`OFS_YEAR, 8'h09);
    carry();
    rd(`OFS_MONTH, 8'h01);
    rd(`OFS_YEAR, 8'h10);
    wr(`OFS_MONTH, 8'h12);
    wr(`OFS_YEAR, 8'h99);
    carry();
    rd(`OFS_YEAR, 8'h00);
    rd(`OFS_MONTH, 8'h01);
    // carry taken at the read's address edge, so busy stands when read data is captured
    fork
      carry();
      rd(`OFS_SECOND, 8'h80);
    join
    rd(`OFS_SECOND, 8'h00);
    rd(`OFS_MONTH, 8'h02);
    wr(8'h24, 8'h55);
    rd(8'h24, 8'h00);
    wr(`OFS_PRIO, 8'h01);
    repeat (2) @(posedge hclk);
    check({29'h0, irq_level}, 32'h0000_0001);
    wr(`OFS_IMASK, 8'h02);
    wr(`OFS_IEN, 8'h04);
    repeat (60) @(posedge hclk);
    check({31'h0, irq}, 32'h0000_0001);
    rd(`OFS_IFLAG, 8'h02);
    wr(`OFS_IEN, 8'h00);
    wr(`OFS_IFLAG, 8'h00);
    rd(`OFS_IFLAG, 8'h00);
    repeat (60) @(posedge hclk);
    check({31'h0, irq}, 32'h0000_0000);
    wr(`OFS_SRCSEL, 8'h20);
    wr(`OFS_IEN, 8'h04);
    repeat (60) @(posedge hclk);
    check({31'h0, irq}, 32'h0000_0000);
    rd(`OFS_IFLAG, 8'h02);
    wr(`OFS_SRCSEL, 8'h00);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h0000_0001);
    // second reset in mid-run while the line and level are both active
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    check({29'h0, irq_level}, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`OFS_MONTH, 8'h01);
    rd(`OFS_GUARD, 8'h00);
    // mask comes back cleared, so a pending second must not reach the line
    wr(`OFS_IEN, 8'h04);
    repeat (60) @(posedge hclk);
    check({31'h0, irq}, 32'h0000_0000);
    rd(`OFS_IFLAG, 8'h02);
    report_and_stop();
  end
endmodule
